// *** pkg/meter_pkg.sv ***
/*
 * Shared constants and types of the metering command front end and its
 * configuration register.
 * Assumes a single 20 MHz clock and byte-wide transfers already
 * deframed from the serial link.
 */
package meter_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int SRST_HOLDOFF_NS = 18000;
    localparam int SRST_HOLD_CYC   = (SRST_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // command byte layout
    localparam int CMD_DIR_BIT  = 7;
    localparam int CMD_ADDR_MSB = 5;

    // ==========================================================
    // configuration register
    localparam logic [5:0]  CFG_ADDR  = 6'h09;
    localparam logic [15:0] CFG_RESET = 16'h000C;

    localparam int HIGHPASS_BYPASS_BIT      = 0;
    localparam int POST_MULT_BYPASS_BIT     = 1;
    localparam int PULSE_OUTPUT_DISABLE_BIT = 2;
    localparam int DIP_DETECT_DISABLE_BIT   = 3;
    localparam int CONVERTER_SUSPEND_BIT    = 4;
    localparam int THERMAL_START_BIT        = 5;
    localparam int SOFT_RESET_BIT           = 6;
    localparam int HALF_CYCLE_ACCUM_BIT     = 7;
    localparam int CURRENT_SHORT_BIT        = 8;
    localparam int VOLTAGE_SHORT_BIT        = 9;
    localparam int INPUT_SWAP_BIT           = 10;
    localparam int RATE_SEL_LSB             = 11;
    localparam int SRC_SEL_LSB              = 13;
    localparam int POSITIVE_ONLY_BIT        = 15;

    // ==========================================================
    // waveform sampling
    localparam int         WAVE_W       = 24;
    localparam logic [10:0] WAVE_BASE_DIV = 11'h0080;

    localparam logic [1:0] SRC_POWER    = 2'h0;
    localparam logic [1:0] SRC_RESERVED = 2'h1;
    localparam logic [1:0] SRC_CH1      = 2'h2;
    localparam logic [1:0] SRC_CH2      = 2'h3;

    // ==========================================================
    // transfer sequencer states, gray along cmd -> data -> cmd
    typedef enum logic [1:0] {
        ST_CMD   = 2'h0,
        ST_WRITE = 2'h1,
        ST_READ  = 2'h2,
        ST_HOLD  = 2'h3
    } xfer_state_t;

endpackage

// *** pkg/wave_if.sv ***
/*
 * Carrier between the register front end and the waveform sampler.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
interface wave_if #(parameter int W = 24);
    logic [1:0]   rate_sel;
    logic [1:0]   src_sel;
    logic         restart;
    logic [W-1:0] power;
    logic [W-1:0] ch1;
    logic [W-1:0] ch2;
    logic [W-1:0] sample;
    logic         tick;

    modport ctrl (output rate_sel, output src_sel, output restart,
                  output power, output ch1, output ch2,
                  input sample, input tick);
    modport gen  (input rate_sel, input src_sel, input restart,
                  input power, input ch1, input ch2,
                  output sample, output tick);
endinterface

// *** hdl/waveform_sampler.sv ***
/*
 * Waveform sampler: picks the selected source and latches it at the
 * selected fraction of the input clock.
 * Assumes the block clock is the device input clock.
 */
`timescale 1ns/10ps
module waveform_sampler #(
    parameter int W = meter_pkg::WAVE_W
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // control and data
    wave_if.gen       wv
);
    typedef struct packed {
        logic [9:0]   cnt;
        logic [W-1:0] sample;
        logic         tick;
    } wave_regs_t;

    wave_regs_t r_ff;
    wave_regs_t nxt_r;
    logic [10:0] lim;

    if (W < 1) begin : g_chk
        $error("waveform width must be at least one");
    end

    assign wv.sample = r_ff.sample;
    assign wv.tick   = r_ff.tick;

    // ==========================================================
    // divider and source latch
    always_comb begin
        nxt_r      = r_ff;
        nxt_r.tick = 1'b0;
        lim        = (meter_pkg::WAVE_BASE_DIV << wv.rate_sel) - 11'h0001;
        if (wv.restart) begin
            nxt_r.cnt = 10'h000;
        end else if ({1'b0, r_ff.cnt} >= lim) begin
            nxt_r.cnt  = 10'h000;
            nxt_r.tick = 1'b1;
            case (wv.src_sel)
                meter_pkg::SRC_POWER: nxt_r.sample = wv.power;
                meter_pkg::SRC_CH1:   nxt_r.sample = wv.ch1;
                meter_pkg::SRC_CH2:   nxt_r.sample = wv.ch2;
                // reserved code keeps the last sample rather than inventing one
                default:              nxt_r.sample = r_ff.sample;
            endcase
        end else begin
            nxt_r.cnt = r_ff.cnt + 10'h001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end
endmodule

// *** hdl/meter_command_and_mode_regs.sv ***
/*
 * Command front end and operating configuration register of the
 * energy meter. Bytes arrive already deframed; every transfer opens
 * with a command byte naming direction and register index.
 * Assumes the serial deframer delivers one byte per rx_valid pulse,
 * and that read bytes are clocked out by dummy bytes from the host.
 */
`timescale 1ns/10ps
module meter_command_and_mode_regs #(
    parameter int WAVE_W = meter_pkg::WAVE_W
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // byte stream from the host
    input  wire logic              rx_valid,
    input  wire logic [7:0]        rx_data,
    output      logic              link_ready,
    // read bytes to the host
    output      logic              tx_valid,
    output      logic [7:0]        tx_data,
    // filter and output control
    output      logic              highpass_bypass,
    output      logic              post_multiplier_filter_bypass,
    output      logic              pulse_output_disable,
    output      logic              dip_detect_disable,
    output      logic              converter_suspend,
    output      logic              half_cycle_accumulation_mode,
    output      logic              positive_only_accumulation,
    // analog front end control
    output      logic              current_input_short,
    output      logic              voltage_input_short,
    output      logic              input_swap,
    // thermal conversion
    output      logic              thermal_conversion_start,
    input  wire logic              thermal_done,
    // soft reset
    output      logic              soft_reset,
    // waveform sampling
    input  wire logic [WAVE_W-1:0] active_power,
    input  wire logic [WAVE_W-1:0] current_sample,
    input  wire logic [WAVE_W-1:0] voltage_sample,
    output      logic [WAVE_W-1:0] waveform_data,
    output      logic              waveform_tick
);
    localparam logic [8:0] HOLD_LAST = 9'(meter_pkg::SRST_HOLD_CYC - 1);

    typedef struct packed {
        meter_pkg::xfer_state_t st;
        logic [5:0]             addr;
        logic                   left;
        logic [15:0]            shift;
        logic [15:0]            cfg;
        logic [8:0]             hold;
        logic [7:0]             tx;
        logic                   tx_v;
        logic                   srst;
    } front_regs_t;

    front_regs_t r_ff;
    front_regs_t nxt_r;

    if (WAVE_W < 1) begin : g_chk
        $error("waveform width must be at least one");
    end
    if (meter_pkg::SRST_HOLD_CYC > 512) begin : g_hold_chk
        $error("soft reset hold-off does not fit its counter");
    end

    wave_if #(.W(WAVE_W)) wv ();

    waveform_sampler #(
        .W(WAVE_W)
    ) u_sampler (
        .clock(clock),
        .rst_n(rst_n),
        .wv   (wv.gen)
    );

    // ==========================================================
    // waveform control
    assign wv.rate_sel = r_ff.cfg[meter_pkg::RATE_SEL_LSB +: 2];
    assign wv.src_sel  = r_ff.cfg[meter_pkg::SRC_SEL_LSB +: 2];
    assign wv.restart  = r_ff.srst;
    assign wv.power    = active_power;
    assign wv.ch1      = current_sample;
    assign wv.ch2      = voltage_sample;
    assign waveform_data = wv.sample;
    assign waveform_tick = wv.tick;

    // ==========================================================
    // configuration bits out
    assign highpass_bypass               = r_ff.cfg[meter_pkg::HIGHPASS_BYPASS_BIT];
    assign post_multiplier_filter_bypass = r_ff.cfg[meter_pkg::POST_MULT_BYPASS_BIT];
    assign pulse_output_disable          = r_ff.cfg[meter_pkg::PULSE_OUTPUT_DISABLE_BIT];
    assign dip_detect_disable            = r_ff.cfg[meter_pkg::DIP_DETECT_DISABLE_BIT];
    assign converter_suspend             = r_ff.cfg[meter_pkg::CONVERTER_SUSPEND_BIT];
    assign thermal_conversion_start      = r_ff.cfg[meter_pkg::THERMAL_START_BIT];
    assign half_cycle_accumulation_mode  = r_ff.cfg[meter_pkg::HALF_CYCLE_ACCUM_BIT];
    assign current_input_short           = r_ff.cfg[meter_pkg::CURRENT_SHORT_BIT];
    assign voltage_input_short           = r_ff.cfg[meter_pkg::VOLTAGE_SHORT_BIT];
    assign input_swap                    = r_ff.cfg[meter_pkg::INPUT_SWAP_BIT];
    assign positive_only_accumulation    = r_ff.cfg[meter_pkg::POSITIVE_ONLY_BIT];

    // ==========================================================
    // link side
    assign soft_reset = r_ff.srst;
    assign tx_valid   = r_ff.tx_v;
    assign tx_data    = r_ff.tx;
    // bytes offered during the hold-off are dropped, so say so
    assign link_ready = (r_ff.st != meter_pkg::ST_HOLD);

    // ==========================================================
    // transfer sequencer
    always_comb begin
        nxt_r      = r_ff;
        nxt_r.tx_v = 1'b0;
        nxt_r.srst = 1'b0;

        // conversion end clears the start bit; a write below may set it again
        if (thermal_done) begin
            nxt_r.cfg[meter_pkg::THERMAL_START_BIT] = 1'b0;
        end

        case (r_ff.st)
            meter_pkg::ST_CMD: begin
                // the command byte sets addr/left/state; shift gets cfg on a read of CFG_ADDR, zero otherwise
                if (rx_valid) begin
                    nxt_r.addr = rx_data[meter_pkg::CMD_ADDR_MSB:0];
                    nxt_r.left = (rx_data[meter_pkg::CMD_ADDR_MSB:0]
                                  == meter_pkg::CFG_ADDR);
                    if (rx_data[meter_pkg::CMD_DIR_BIT]) begin
                        nxt_r.st    = meter_pkg::ST_WRITE;
                        nxt_r.shift = 16'h0000;
                    end else begin
                        nxt_r.st = meter_pkg::ST_READ;
                        // unmapped indices read back as zero
                        if (rx_data[meter_pkg::CMD_ADDR_MSB:0] == meter_pkg::CFG_ADDR) begin
                            nxt_r.shift = r_ff.cfg;
                        end else begin
                            nxt_r.shift = 16'h0000;
                        end
                    end
                end
            end

            meter_pkg::ST_WRITE: begin
                if (rx_valid) begin
                    nxt_r.shift = {r_ff.shift[7:0], rx_data};
                    if (r_ff.left) begin
                        nxt_r.left = 1'b0;
                    end else begin
                        nxt_r.st = meter_pkg::ST_CMD;
                        if (r_ff.addr == meter_pkg::CFG_ADDR) begin
                            if (rx_data[meter_pkg::SOFT_RESET_BIT]) begin
                                // configuration returns to defaults, host must back off
                                nxt_r.cfg  = meter_pkg::CFG_RESET;
                                nxt_r.srst = 1'b1;
                                nxt_r.hold = 9'h000;
                                nxt_r.st   = meter_pkg::ST_HOLD;
                            end else begin
                                nxt_r.cfg = {r_ff.shift[7:0], rx_data};
                                // a fresh start request beats a finishing conversion
                                if (!rx_data[meter_pkg::THERMAL_START_BIT] &&
                                    r_ff.cfg[meter_pkg::THERMAL_START_BIT] &&
                                    !thermal_done) begin
                                    nxt_r.cfg[meter_pkg::THERMAL_START_BIT] = 1'b1;
                                end
                            end
                        end
                    end
                end
            end

            meter_pkg::ST_READ: begin
                if (rx_valid) begin
                    nxt_r.tx    = r_ff.shift[15:8];
                    nxt_r.tx_v  = 1'b1;
                    nxt_r.shift = {r_ff.shift[7:0], 8'h00};
                    if (r_ff.left) begin
                        nxt_r.left = 1'b0;
                    end else begin
                        nxt_r.st = meter_pkg::ST_CMD;
                    end
                end
            end

            meter_pkg::ST_HOLD: begin
                if (r_ff.hold >= HOLD_LAST) begin
                    nxt_r.st = meter_pkg::ST_CMD;
                end else begin
                    nxt_r.hold = r_ff.hold + 9'h001;
                end
            end

            default: begin
                nxt_r.st = meter_pkg::ST_CMD;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_ff       <= '0;
            r_ff.st    <= meter_pkg::ST_CMD;
            r_ff.cfg   <= meter_pkg::CFG_RESET;
        end else begin
            r_ff <= nxt_r;
        end
    end
endmodule

// *** tb/meter_regs_monitor.sv ***
/* Checker of the meter command front end and configuration outputs.
   Sees only the top ports; bound to the top module below. */
`timescale 1ns/10ps
module meter_regs_monitor #(
    parameter int WAVE_W = 24
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    // watched ports
    input wire logic              rx_valid,
    input wire logic              link_ready,
    input wire logic              tx_valid,
    input wire logic              highpass_bypass,
    input wire logic              pulse_output_disable,
    input wire logic              dip_detect_disable,
    input wire logic              positive_only_accumulation,
    input wire logic              thermal_conversion_start,
    input wire logic              thermal_done,
    input wire logic              soft_reset,
    input wire logic [WAVE_W-1:0] waveform_data,
    input wire logic              waveform_tick
);
    // ==========================================================
    // helpers: cycles since last tick, cycles of hold-off
    logic [10:0] gap_ff;
    logic [9:0]  low_ff;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff <= 11'h7FF;
            low_ff <= 10'h000;
        end else begin
            // saturated value means no tick to measure from
            gap_ff <= soft_reset ? 11'h7FF : waveform_tick ? 11'h000 :
                      gap_ff + {10'h000, gap_ff != 11'h7FF};
            low_ff <= link_ready ? 10'h000 : low_ff + 10'h001;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // assertions
    chk_srst_cfg_home: assert property (soft_reset |->
        pulse_output_disable && dip_detect_disable && !highpass_bypass)
        else $error("cfg not home on soft reset");
    chk_srst_one_pulse: assert property (soft_reset |=> !soft_reset)
        else $error("soft reset longer than one cycle");
    chk_srst_link_off: assert property (soft_reset |-> !link_ready)
        else $error("link open during soft reset");
    chk_holdoff_span: assert property ($rose(link_ready) |->
        low_ff == 10'(meter_pkg::SRST_HOLD_CYC)) else $error("hold-off length wrong");
    chk_thermal_clear: assert property ($fell(thermal_conversion_start) |->
        $past(thermal_done) || soft_reset) else $error("thermal start fell alone");
    chk_tx_from_dummy: assert property (tx_valid |-> $past(rx_valid))
        else $error("read byte without a host byte");
    chk_wave_hold: assert property (!waveform_tick |-> $stable(waveform_data))
        else $error("waveform changed without tick");
    chk_tick_gap: assert property (waveform_tick |-> gap_ff >= 11'h07F)
        else $error("waveform ticks too close");
    chk_cfg_quiet: assert property (!$past(rx_valid) |-> $stable({
        highpass_bypass, pulse_output_disable, dip_detect_disable,
        positive_only_accumulation})) else $error("cfg changed without a byte");
    cov_srst: cover property (soft_reset);
    cov_read_pair: cover property (tx_valid ##1 tx_valid);
    cov_thermal: cover property ($fell(thermal_conversion_start));
endmodule
bind meter_command_and_mode_regs meter_regs_monitor #(.WAVE_W(WAVE_W)) i_mon (
    .clock(clock), .rst_n(rst_n), .rx_valid(rx_valid), .link_ready(link_ready),
    .tx_valid(tx_valid), .highpass_bypass(highpass_bypass),
    .pulse_output_disable(pulse_output_disable), .dip_detect_disable(dip_detect_disable),
    .positive_only_accumulation(positive_only_accumulation),
    .thermal_conversion_start(thermal_conversion_start), .thermal_done(thermal_done),
    .soft_reset(soft_reset), .waveform_data(waveform_data), .waveform_tick(waveform_tick));

// *** tb/host_model.sv ***
/* Host model: sends command and data bytes, one per cycle.
   Assumes bytes are taken on rising edges while link_ready is high. */
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic       clock,
    // byte link
    input wire logic       link_ready,
    output     logic       rx_valid,
    output     logic [7:0] rx_data
);
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end
    // ==========================================================
    // byte level
    task automatic put(input logic [7:0] b);
        @(negedge clock);
        while (link_ready !== 1'b1) begin
            rx_valid = 1'b0;
            @(negedge clock);
        end
        rx_valid = 1'b1;
        rx_data  = b;
    endtask
    // released line shows the inverse so stale data never looks valid
    task automatic stop();
        @(negedge clock);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask
    // ==========================================================
    // transfers: command first, bit 6 clear, msb byte first
    task automatic wr(input logic [5:0] a, input logic [15:0] v, input int n);
        put({1'b1, 1'b0, a});
        if (n == 2) put(v[15:8]);
        put(v[7:0]);
        stop();
    endtask
    task automatic rd(input logic [5:0] a, input int n);
        put({1'b0, 1'b0, a});
        repeat (n) put(~rx_data);
        stop();
    endtask
endmodule

// *** tb/meter_command_and_mode_regs_tb.sv ***
/* Self-checking bench of the meter command front end.
   Assumes the host model drives the byte link and the checker is bound. */
`timescale 1ns/10ps
module meter_command_and_mode_regs_tb;
    localparam int W = 24;
    localparam logic [15:0] MASK = 16'h87BF;
    logic          clock, rst_n, rx_valid, link_ready, tx_valid;
    logic          thermal_done, soft_reset, waveform_tick;
    logic [7:0]    rx_data, tx_data;
    logic [W-1:0]  power_i, ch1_i, ch2_i, waveform_data, exp_w;
    wire  [15:0]   cfg_o;
    logic [15:0]   v;
    logic [1:0]    s;
    logic [7:0]    exp_q[$];
    int            err_total, n_compared, seed, n;
    meter_command_and_mode_regs #(.WAVE_W(W)) i_dut (
        .clock(clock), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .link_ready(link_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .highpass_bypass(cfg_o[0]), .post_multiplier_filter_bypass(cfg_o[1]),
        .pulse_output_disable(cfg_o[2]), .dip_detect_disable(cfg_o[3]),
        .converter_suspend(cfg_o[4]), .thermal_conversion_start(cfg_o[5]),
        .half_cycle_accumulation_mode(cfg_o[7]), .current_input_short(cfg_o[8]),
        .voltage_input_short(cfg_o[9]), .input_swap(cfg_o[10]),
        .positive_only_accumulation(cfg_o[15]), .thermal_done(thermal_done),
        .soft_reset(soft_reset), .active_power(power_i), .current_sample(ch1_i),
        .voltage_sample(ch2_i), .waveform_data(waveform_data),
        .waveform_tick(waveform_tick));
    host_model i_host (.clock(clock), .link_ready(link_ready), .rx_valid(rx_valid),
        .rx_data(rx_data));
    // soft reset and waveform fields have no level pin; masked in chk_cfg
    assign cfg_o[6]     = 1'b0;
    assign cfg_o[14:11] = 4'h0;
    // ==========================================================
    // compare and close
    task automatic cmp_val(input string what, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] e);
        cmp_val("tx_data", 24'(e), 24'(tx_data));
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(negedge clock) begin
        if (tx_valid === 1'b1) begin
            if (exp_q.size() == 0) cmp_val("tx surplus", 24'h00_0000, 24'(tx_data));
            else cmp_byte(exp_q.pop_front());
        end
    end
    // ==========================================================
    // stimulus helpers
    task automatic rdq(input logic [5:0] a, input logic [15:0] e, input int k);
        if (k == 2) exp_q.push_back(e[15:8]);
        exp_q.push_back(e[7:0]);
        i_host.rd(a, k);
        repeat (2) @(negedge clock);
    endtask
    task automatic chk_cfg(input logic [15:0] e);
        cmp_val("cfg", 24'(e & MASK), 24'(cfg_o & MASK));
    endtask
    // bounded so a dead divider cannot hang the run
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(negedge clock);
            c++;
        end while (waveform_tick !== 1'b1 && c < 3000);
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #(20000 * 50);
        err_total++;
        close_out();
    end
    // ==========================================================
    // main sequence
    initial begin
        seed = 42992;
        rst_n = 1'b0;
        thermal_done = 1'b0;
        power_i = 24'($random(seed));
        ch1_i = 24'($random(seed));
        ch2_i = 24'($random(seed));
        exp_w = 24'h00_0000;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        chk_cfg(16'h000C);
        rdq(6'h09, 16'h000C, 2);
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed)) & 16'hFF9F;
            i_host.wr(6'h09, v, 2);
            @(negedge clock);
            chk_cfg(v);
            rdq(6'h09, v, 2);
        end
        // neighbours of the index one bit away must not touch it
        for (int b = 0; b < 6; b++) begin
            i_host.wr(6'h09 ^ 6'(1 << b), 16'h00FF, 1);
            rdq(6'h09 ^ 6'(1 << b), 16'h0000, 1);
        end
        rdq(6'h09, v, 2);
        i_host.wr(6'h09, 16'h0020, 2);
        @(negedge clock);
        chk_cfg(16'h0020);
        thermal_done = 1'b1;
        @(negedge clock);
        thermal_done = 1'b0;
        @(negedge clock);
        chk_cfg(16'h0000);
        // conversion end and a fresh start in one cycle: the start stays
        fork
            i_host.wr(6'h09, 16'h0020, 2);
            begin
                repeat (3) @(negedge clock);
                thermal_done = 1'b1;
                @(negedge clock);
                thermal_done = 1'b0;
            end
        join
        chk_cfg(16'h0020);
        i_host.wr(6'h09, 16'h8143, 2);
        // soft reset pulse stands only in the cycle right after the commit
        cmp_val("soft_reset", 24'h00_0001, 24'(soft_reset));
        cmp_val("link_ready", 24'h00_0000, 24'(link_ready));
        chk_cfg(16'h000C);
        rdq(6'h09, 16'h000C, 2);
        for (int k = 0; k < 4; k++) begin
            s = (k == 0) ? 2'h0 : (k == 1) ? 2'h2 : (k == 2) ? 2'h3 : 2'h1;
            i_host.wr(6'h09, {1'b0, s, 2'(k), 11'h000}, 2);
            exp_w = (s == 2'h0) ? power_i : (s == 2'h2) ? ch1_i :
                    (s == 2'h3) ? ch2_i : exp_w;
            wait_tick(n);
            wait_tick(n);
            cmp_val("tick gap", 24'(128 << k), 24'(n));
            cmp_val("waveform", exp_w, waveform_data);
        end
        cmp_val("reads left", 24'h00_0000, 24'(exp_q.size()));
        close_out();
    end
endmodule
